// *** inc/rps_pkg.sv ***
// package for the ring port statistics block: map, field codes, timing
package rps_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned CNT_W   = 32;   // every counter width
  localparam int unsigned ADDR_W  = 8;    // register word address width
  localparam int unsigned NCLS    = 5;    // destination classes
  localparam int unsigned NOUT    = 5;    // forwarding outcomes
  localparam int unsigned NRXCAT  = 25;   // class x outcome pairs

  // ------------------------------------------------------------
  // register word addresses
  // ------------------------------------------------------------
  localparam logic [7:0] A_RX_CAT0     = 8'h00; // 0x00..0x18 rx categories
  localparam logic [7:0] A_TX_CAT0     = 8'h20; // 0x20..0x24 tx categories
  localparam logic [7:0] A_RX_FWD_B    = 8'h30;
  localparam logic [7:0] A_RX_FLT_B    = 8'h31;
  localparam logic [7:0] A_RX_SIZE     = 8'h32;
  localparam logic [7:0] A_RX_FCS      = 8'h33;
  localparam logic [7:0] A_TX_CONG     = 8'h34;
  localparam logic [7:0] A_TX_STORM    = 8'h35;
  localparam logic [7:0] A_TX_DEST     = 8'h36;
  localparam logic [7:0] A_TX_OVSZ     = 8'h37;
  localparam logic [7:0] A_RX_STARVE   = 8'h38;
  localparam logic [7:0] A_TX_TOTAL    = 8'h39;
  localparam logic [7:0] A_RX_TOTAL    = 8'h3A;
  localparam logic [7:0] A_BUFFERS     = 8'h3B;
  localparam logic [7:0] A_STATUS      = 8'h3C;
  localparam logic [7:0] A_CONTROL     = 8'h3D;

  // ------------------------------------------------------------
  // status word fields and reset values
  // ------------------------------------------------------------
  localparam int unsigned ST_RING_LSB  = 0;  // [1:0] ring state
  localparam int unsigned ST_SPAN_LSB  = 4;  // [6:4] spanning tree
  localparam int unsigned ST_RSTAT_LSB = 8;  // [11:8] ring status
  localparam logic [1:0]  CTRL_RST     = 2'h0; // bit0 speed16, bit1 processor_ready_led ready
  localparam int unsigned CTRL_SPEED   = 0;
  localparam int unsigned CTRL_PROCESSOR_READY_LED    = 1;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  // ------------------------------------------------------------
  // indicator timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned FLASH_MS     = 50;  // indicator hold per activity; led lit for the first half
  localparam int unsigned FLASH_CYC    = FLASH_MS * 1000 * CLK_MHZ;

  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DST_MGMT_UC, DST_MGMT_MC, DST_KNOWN, DST_UNK_UC, DST_UNK_MC
  } rps_dst_t;

  typedef enum logic [2:0] {
    OUT_FWD, OUT_LOCAL, OUT_BLOCKED, OUT_SRC, OUT_DST
  } rps_out_t;

  typedef enum logic [1:0] {
    RING_OPENED, RING_CLOSED, RING_FAILURE
  } rps_ring_t;

  typedef enum logic [2:0] {
    SPAN_BLOCKING, SPAN_LISTENING, SPAN_LEARNING, SPAN_FORWARDING,
    SPAN_BROKEN, SPAN_DISABLED
  } rps_span_t;

  typedef enum logic [3:0] {
    RS_NO_PROBLEMS, RS_RECOVERY, RS_SINGLE, RS_AUTO_REMOVAL, RS_LOBE_FAULT,
    RS_SOFT_ERR, RS_HARD_ERR, RS_TX_BEACON, RS_SIGNAL_LOSS, RS_REMOVE_RCVD
  } rps_rstat_t;

  // ------------------------------------------------------------
  // event carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic             valid;   // one-cycle pulse: packet done
    logic             good;    // no reception error
    logic             hw_local; // dropped by local hardware filter
    rps_dst_t         dst;
    rps_out_t         outcome;
    logic [15:0]      bytes;   // character count
  } rps_rx_evt_t;

  typedef struct packed {
    logic             valid;   // one-cycle pulse: packet sent
    rps_dst_t         dst;
  } rps_tx_evt_t;

  typedef struct packed {
    logic size_err;
    logic fcs_err;
    logic starve;
    logic congest;
    logic storm;
    logic dest_flt;
    logic oversize;
  } rps_drop_t;

endpackage

// *** hdl/rps_port_stats.sv ***
// ring port statistics: counters, status words and front panel indicators
`timescale 1ns/1ps
// What this block does
// R1 - one rx counter per class-outcome pair
// R2 - five destination address classes
// R3 - five forwarding outcome classes
// R4 - sum bytes of forwarded rx packets
// R5 - sum bytes of filtered rx packets
// R6 - count rx discards for bad length
// R7 - count rx discards for checksum failure
// R8 - five 32-bit tx counters by class
// R9 - count tx drops from congestion
// R10 - count tx drops from storm protection
// R11 - count tx drops from destination filter
// R12 - count tx drops for oversize
// R13 - tx total includes errored transmissions
// R14 - rx total counts only good packets
// R15 - count starvation drops, report buffer count
// R16 - clear all counters on reset/restart
// R17 - read-only ring state, three values
// R18 - read-only spanning tree state, forwarding passes
// R19 - read-only ring status code
// R20 - flash rx and tx indicators on activity
// R21 - ring led lit while inserted
// R22 - speed led lit at higher rate
// R23 - counters 32 bits, wrap silently
module rps_port_stats #(
  parameter int unsigned FLASH_CYCLES = rps_pkg::FLASH_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     srst_i,
  input  wire logic                     restart_i,
  input  wire rps_pkg::rps_rx_evt_t     rx_evt_i,
  input  wire rps_pkg::rps_tx_evt_t     tx_evt_i,
  input  wire logic                     tx_err_i,
  input  wire rps_pkg::rps_drop_t       drop_i,
  input  wire logic [15:0]              buffers_i,
  input  wire rps_pkg::rps_ring_t       ring_state_i,
  input  wire rps_pkg::rps_span_t       span_state_i,
  input  wire rps_pkg::rps_rstat_t      ring_status_i,
  input  wire logic                     inserted_i,
  input  wire logic [7:0]               addr_i,
  input  wire logic [31:0]              wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output logic [31:0]                   rdata_o,
  output logic                          span_pass_o,
  output logic                          rx_led_o,
  output logic                          tx_led_o,
  output logic                          ring_inserted_led_o,
  output logic                          speed_led_o,
  output logic                          processor_ready_led_o
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (FLASH_CYCLES < 2 || FLASH_CYCLES > 32'hFFFF_FFFF) begin : g_chk
    $error("FLASH_CYCLES out of range");
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [31:0] rx_category_count [rps_pkg::NRXCAT]; // class x outcome
  logic [31:0] tx_category_count [rps_pkg::NCLS];   // per class
  logic [31:0] rx_forwarded_bytes;
  logic [31:0] rx_filtered_bytes;
  logic [31:0] rx_size_discards;
  logic [31:0] rx_checksum_discards;
  logic [31:0] tx_congestion_drops;
  logic [31:0] tx_storm_drops;
  logic [31:0] tx_dest_filter_drops;
  logic [31:0] tx_oversize_drops;
  logic [31:0] rx_buffer_starvation_drops;
  logic [31:0] tx_total;          // sent plus errored
  logic [31:0] rx_total;          // good packets only
  logic [1:0]  control;           // speed and processor ready
  logic [31:0] rx_flash_cnt;      // rx indicator hold
  logic [31:0] tx_flash_cnt;      // tx indicator hold
  logic        clr;               // counter clear
  logic [4:0]  rx_idx;            // category index
  logic        rx_counted;        // valid rx packet to count

  // counters clear on reset and on port restart
  assign clr = srst_i | restart_i;

  // ------------------------------------------------------------
  // classification
  // ------------------------------------------------------------
  // R2 five classes
  // R3 five outcomes
  assign rx_idx = 5'(int'(rx_evt_i.dst) * rps_pkg::NOUT + int'(rx_evt_i.outcome));
  // rx packets with errors or hardware-filtered never reach the tables
  assign rx_counted = rx_evt_i.valid & rx_evt_i.good & ~rx_evt_i.hw_local
                      & (rx_evt_i.dst <= rps_pkg::DST_UNK_MC)
                      & (rx_evt_i.outcome <= rps_pkg::OUT_DST);

  // ------------------------------------------------------------
  // rx category table
  // ------------------------------------------------------------
  // R1 pairwise counters
  // R16 clear on restart
  // R23 wrap on overflow
  always_ff @(posedge clk_i) begin
    if (clr) begin
      for (int i = 0; i < rps_pkg::NRXCAT; i++) begin
        rx_category_count[i] <= '0;
      end
    end else if (rx_counted) begin
      rx_category_count[rx_idx] <= rx_category_count[rx_idx] + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // rx byte sums and total
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (clr) begin
      rx_forwarded_bytes <= '0;
      rx_filtered_bytes  <= '0;
      rx_total           <= '0;
    end else if (rx_counted) begin
      // R14 good packets only
      rx_total <= rx_total + 32'h0000_0001;
      if (rx_evt_i.outcome == rps_pkg::OUT_FWD) begin
        // R4 forwarded bytes
        rx_forwarded_bytes <= rx_forwarded_bytes + {16'h0000, rx_evt_i.bytes};
      end else begin
        // R5 filtered bytes
        rx_filtered_bytes <= rx_filtered_bytes + {16'h0000, rx_evt_i.bytes};
      end
    end
  end

  // ------------------------------------------------------------
  // rx discard counters
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (clr) begin
      rx_size_discards           <= '0;
      rx_checksum_discards       <= '0;
      rx_buffer_starvation_drops <= '0;
    end else begin
      // R6 length discards
      if (drop_i.size_err) begin
        rx_size_discards <= rx_size_discards + 32'h0000_0001;
      end
      // R7 checksum discards
      if (drop_i.fcs_err) begin
        rx_checksum_discards <= rx_checksum_discards + 32'h0000_0001;
      end
      // R15 buffer starvation
      if (drop_i.starve) begin
        rx_buffer_starvation_drops <= rx_buffer_starvation_drops + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // tx category table and total
  // ------------------------------------------------------------
  // R8 per-class tx counts
  always_ff @(posedge clk_i) begin
    if (clr) begin
      for (int i = 0; i < rps_pkg::NCLS; i++) begin
        tx_category_count[i] <= '0;
      end
    end else if (tx_evt_i.valid && tx_evt_i.dst <= rps_pkg::DST_UNK_MC) begin
      tx_category_count[tx_evt_i.dst] <= tx_category_count[tx_evt_i.dst]
                                         + 32'h0000_0001;
    end
  end

  // R13 errored sends included
  always_ff @(posedge clk_i) begin
    if (clr) begin
      tx_total <= '0;
    end else if (tx_evt_i.valid || tx_err_i) begin
      tx_total <= tx_total + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // tx drop counters
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (clr) begin
      tx_congestion_drops  <= '0;
      tx_storm_drops       <= '0;
      tx_dest_filter_drops <= '0;
      tx_oversize_drops    <= '0;
    end else begin
      // R9 congestion
      if (drop_i.congest) begin
        tx_congestion_drops <= tx_congestion_drops + 32'h0000_0001;
      end
      // R10 storm protection
      if (drop_i.storm) begin
        tx_storm_drops <= tx_storm_drops + 32'h0000_0001;
      end
      // R11 destination filter
      if (drop_i.dest_flt) begin
        tx_dest_filter_drops <= tx_dest_filter_drops + 32'h0000_0001;
      end
      // R12 oversize
      if (drop_i.oversize) begin
        tx_oversize_drops <= tx_oversize_drops + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // control register (software writes)
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      control <= rps_pkg::CTRL_RST;
    end else if (wr_i && addr_i == rps_pkg::A_CONTROL) begin
      control <= wdata_i[1:0];
    end
  end

  // ------------------------------------------------------------
  // register read port, data one cycle after strobe
  // ------------------------------------------------------------
  // R17 ring state
  // R18 spanning state
  // R19 ring status
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      if (addr_i < 8'(rps_pkg::NRXCAT)) begin
        rdata_o <= rx_category_count[addr_i[4:0]];
      end else if (addr_i >= rps_pkg::A_TX_CAT0
                   && addr_i < rps_pkg::A_TX_CAT0 + 8'(rps_pkg::NCLS)) begin
        rdata_o <= tx_category_count[3'(addr_i - rps_pkg::A_TX_CAT0)];
      end else if (addr_i == rps_pkg::A_RX_FWD_B) begin
        rdata_o <= rx_forwarded_bytes;
      end else if (addr_i == rps_pkg::A_RX_FLT_B) begin
        rdata_o <= rx_filtered_bytes;
      end else if (addr_i == rps_pkg::A_RX_SIZE) begin
        rdata_o <= rx_size_discards;
      end else if (addr_i == rps_pkg::A_RX_FCS) begin
        rdata_o <= rx_checksum_discards;
      end else if (addr_i == rps_pkg::A_TX_CONG) begin
        rdata_o <= tx_congestion_drops;
      end else if (addr_i == rps_pkg::A_TX_STORM) begin
        rdata_o <= tx_storm_drops;
      end else if (addr_i == rps_pkg::A_TX_DEST) begin
        rdata_o <= tx_dest_filter_drops;
      end else if (addr_i == rps_pkg::A_TX_OVSZ) begin
        rdata_o <= tx_oversize_drops;
      end else if (addr_i == rps_pkg::A_RX_STARVE) begin
        rdata_o <= rx_buffer_starvation_drops;
      end else if (addr_i == rps_pkg::A_TX_TOTAL) begin
        rdata_o <= tx_total;
      end else if (addr_i == rps_pkg::A_RX_TOTAL) begin
        rdata_o <= rx_total;
      end else if (addr_i == rps_pkg::A_BUFFERS) begin
        // R15 buffer count
        rdata_o <= {16'h0000, buffers_i};
      end else if (addr_i == rps_pkg::A_STATUS) begin
        rdata_o <= {20'h00000, ring_status_i, 1'b0, span_state_i, 2'b00, ring_state_i};
      end else if (addr_i == rps_pkg::A_CONTROL) begin
        rdata_o <= {30'h0000_0000, control};
      end else begin
        rdata_o <= rps_pkg::UNMAPPED_RD;
      end
    end else begin
      rdata_o <= '0;
    end
  end

  // ------------------------------------------------------------
  // activity flash timers
  // ------------------------------------------------------------
  // R20 flash on activity
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_flash_cnt <= '0;
      tx_flash_cnt <= '0;
    end else begin
      if (rx_evt_i.valid) begin
        rx_flash_cnt <= 32'(FLASH_CYCLES);
      end else if (rx_flash_cnt != 32'h0000_0000) begin
        rx_flash_cnt <= rx_flash_cnt - 32'h0000_0001;
      end
      if (tx_evt_i.valid || tx_err_i) begin
        tx_flash_cnt <= 32'(FLASH_CYCLES);
      end else if (tx_flash_cnt != 32'h0000_0000) begin
        tx_flash_cnt <= tx_flash_cnt - 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // indicator registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_led_o              <= 1'b0;
      tx_led_o              <= 1'b0;
      ring_inserted_led_o   <= 1'b0;
      speed_led_o           <= 1'b0;
      processor_ready_led_o <= 1'b0;
      span_pass_o           <= 1'b0;
    end else begin
      // blink: lit during first half of the hold time
      rx_led_o <= rx_flash_cnt > 32'(FLASH_CYCLES / 2);
      tx_led_o <= tx_flash_cnt > 32'(FLASH_CYCLES / 2);
      // R21 inserted indicator
      ring_inserted_led_o   <= inserted_i;
      // R22 speed indicator
      speed_led_o           <= control[rps_pkg::CTRL_SPEED];
      processor_ready_led_o <= control[rps_pkg::CTRL_PROCESSOR_READY_LED];
      // R18 only forwarding passes
      span_pass_o <= (span_state_i == rps_pkg::SPAN_FORWARDING);
    end
  end

endmodule

// *** tb/rps_port_stats_assertions.sv ***
// assertion checker watching the ring port statistics ports
`timescale 1ns/1ps
module rps_port_stats_checker #(
  parameter int unsigned FLASH_CYCLES = rps_pkg::FLASH_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire rps_pkg::rps_rx_evt_t rx_evt_i,
  input  wire rps_pkg::rps_tx_evt_t tx_evt_i,
  input  wire rps_pkg::rps_span_t   span_state_i,
  input  wire logic                 inserted_i,
  input  wire logic [7:0]           addr_i,
  input  wire logic [31:0]          wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  input  wire logic [31:0]          rdata_o,
  input  wire logic                 span_pass_o,
  input  wire logic                 rx_led_o,
  input  wire logic                 tx_led_o,
  input  wire logic                 ring_inserted_led_o,
  input  wire logic                 speed_led_o,
  input  wire logic                 processor_ready_led_o
);
  // ------------------------------------------------------------
  // helper: cycles since the last receive activity, saturating
  // ------------------------------------------------------------
  int unsigned rx_idle;  // idle run length
  always_ff @(posedge clk_i) begin
    if (srst_i || rx_evt_i.valid) begin
      rx_idle <= 0;
    end else if (rx_idle < FLASH_CYCLES + 4) begin
      rx_idle <= rx_idle + 1;
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_read_zero: assert property (
    rd_i && addr_i inside {[8'h19:8'h1F], [8'h3E:8'hFF]} |=> rdata_o == 32'h0)
    else $error("unmapped read returned nonzero");
  a_span_pass_follow: assert property (
    !$past(srst_i) |-> span_pass_o == ($past(span_state_i) == rps_pkg::SPAN_FORWARDING))
    else $error("pass flag does not follow forwarding state");
  a_ring_led_follow: assert property (
    !$past(srst_i) |-> ring_inserted_led_o == $past(inserted_i))
    else $error("ring led does not follow insertion");
  a_rx_led_flash: assert property (
    rx_evt_i.valid && rx_evt_i.good && !rx_evt_i.hw_local |-> ##[1:2] rx_led_o)
    else $error("receive led not lit on activity");
  a_tx_led_flash: assert property (tx_evt_i.valid |-> ##[1:2] tx_led_o)
    else $error("transmit led not lit on activity");
  a_rx_led_dark: assert property (rx_idle > FLASH_CYCLES + 2 |-> !rx_led_o)
    else $error("receive led lit while idle");
  a_speed_led_set: assert property (
    wr_i && addr_i == rps_pkg::A_CONTROL && wdata_i[0] |-> ##[1:2] speed_led_o)
    else $error("speed led not lit after control write");
  a_processor_ready_led_led_clear: assert property (
    wr_i && addr_i == rps_pkg::A_CONTROL && !wdata_i[1] |-> ##[1:2] !processor_ready_led_o)
    else $error("processor led not cleared after control write");

  c_rx_event: cover property (rx_evt_i.valid && rx_evt_i.good);
  c_tx_event: cover property (tx_evt_i.valid);
  c_ctrl_write: cover property (wr_i && addr_i == rps_pkg::A_CONTROL);
  c_read_data: cover property (rd_i ##1 rdata_o != 32'h0);
endmodule

bind rps_port_stats rps_port_stats_checker #(.FLASH_CYCLES(FLASH_CYCLES)) rps_chk_i (
  .clk_i(clk_i), .srst_i(srst_i), .rx_evt_i(rx_evt_i), .tx_evt_i(tx_evt_i),
  .span_state_i(span_state_i), .inserted_i(inserted_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .span_pass_o(span_pass_o), .rx_led_o(rx_led_o), .tx_led_o(tx_led_o),
  .ring_inserted_led_o(ring_inserted_led_o), .speed_led_o(speed_led_o),
  .processor_ready_led_o(processor_ready_led_o)
);

// *** tb/rps_dp_model.sv ***
// model of the forwarding datapath that reports packet events
`timescale 1ns/1ps
module rps_dp_model (
  input  wire logic            clk_i,
  output rps_pkg::rps_rx_evt_t rx_evt_o,
  output rps_pkg::rps_tx_evt_t tx_evt_o,
  output logic                 tx_err_o,
  output rps_pkg::rps_drop_t   drop_o
);
  // idle: every strobe low
  initial begin
    rx_evt_o = '0;
    tx_evt_o = '0;
    tx_err_o = 1'b0;
    drop_o   = '0;
  end
  // one received packet; qualifiers scrambled once the pulse ends
  task automatic rx(input logic [2:0] dst, input logic [2:0] oc, input logic [15:0] n,
                    input logic good, input logic hwl);
    @(posedge clk_i);
    rx_evt_o <= {1'b1, good, hwl, dst, oc, n};
    @(posedge clk_i);
    rx_evt_o <= {1'b0, ~good, ~hwl, ~dst, ~oc, ~n};
  endtask
  // one sent packet and/or a transmit error pulse
  task automatic tx(input logic [2:0] dst, input logic err, input logic snd);
    @(posedge clk_i);
    tx_evt_o <= {snd, dst};
    tx_err_o <= err;
    @(posedge clk_i);
    tx_evt_o <= {1'b0, ~dst};
    tx_err_o <= 1'b0;
  endtask
  // a set of drop reasons in one cycle
  task automatic drop(input logic [6:0] p);
    @(posedge clk_i);
    drop_o <= p;
    @(posedge clk_i);
    drop_o <= '0;
  endtask
endmodule

// *** tb/ring_port_statistics_test.sv ***
// self-checking bench for the ring port statistics block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin fail_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module ring_port_statistics_test;
  logic                 clk_i = 1'b0;
  logic                 srst_i, restart_i, inserted_i, wr_i, rd_i, rd_q;
  rps_pkg::rps_rx_evt_t rx_evt;
  rps_pkg::rps_tx_evt_t tx_evt;
  rps_pkg::rps_drop_t   drop;
  logic                 tx_err, span_pass_o, rx_led_o, tx_led_o;
  logic                 ring_inserted_led_o, speed_led_o, processor_ready_led_o;
  logic [15:0]          buffers_i, n;
  rps_pkg::rps_ring_t   ring_state_i;
  rps_pkg::rps_span_t   span_state_i;
  rps_pkg::rps_rstat_t  ring_status_i;
  logic [7:0]           addr_i;
  logic [31:0]          wdata_i, rdata_o, fwd, flt, exp_now, seed;
  logic [31:0]          expq[$];  // expected read answers, oldest first
  logic [7:0]           dadr[7] = '{rps_pkg::A_TX_OVSZ, rps_pkg::A_TX_DEST,
    rps_pkg::A_TX_STORM, rps_pkg::A_TX_CONG, rps_pkg::A_RX_STARVE, rps_pkg::A_RX_FCS,
    rps_pkg::A_RX_SIZE};  // drop counter per drop bit
  int                   fail_count, checks, cyc, i;

  // ------------------------------------------------------------
  // clock, design and datapath model
  // ------------------------------------------------------------
  always #5 clk_i = ~clk_i;
  rps_port_stats #(.FLASH_CYCLES(8)) rps_port_stats_i (
    .clk_i(clk_i), .srst_i(srst_i), .restart_i(restart_i), .rx_evt_i(rx_evt),
    .tx_evt_i(tx_evt), .tx_err_i(tx_err), .drop_i(drop), .buffers_i(buffers_i),
    .ring_state_i(ring_state_i), .span_state_i(span_state_i),
    .ring_status_i(ring_status_i), .inserted_i(inserted_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .span_pass_o(span_pass_o), .rx_led_o(rx_led_o), .tx_led_o(tx_led_o),
    .ring_inserted_led_o(ring_inserted_led_o), .speed_led_o(speed_led_o),
    .processor_ready_led_o(processor_ready_led_o));
  rps_dp_model rps_dp_model_i (.clk_i(clk_i), .rx_evt_o(rx_evt), .tx_evt_o(tx_evt),
    .tx_err_o(tx_err), .drop_o(drop));

  // ------------------------------------------------------------
  // register bus tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; rd_i <= 1'b0; addr_i <= a; wdata_i <= d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1; wr_i <= 1'b0; addr_i <= a; wdata_i <= $random(seed);
    expq.push_back(e);
  endtask
  task automatic idle;
    @(posedge clk_i);
    rd_i <= 1'b0; wr_i <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // monitor: compares each read answer with the oldest note; cuts hangs
  always @(posedge clk_i) begin
    cyc++;
    if (rd_q) begin
      exp_now = expq.pop_front();
      `CHK("rdata", exp_now, rdata_o)
    end
    rd_q <= rd_i;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h99AE6FC0; srst_i = 1'b1; restart_i = 1'b0; inserted_i = 1'b0;
    wr_i = 1'b0; rd_i = 1'b0; rd_q = 1'b0; addr_i = 8'h0; wdata_i = 32'h0;
    buffers_i = 16'h0; ring_state_i = rps_pkg::RING_OPENED; fwd = 32'h0; flt = 32'h0;
    span_state_i = rps_pkg::SPAN_BLOCKING; ring_status_i = rps_pkg::RS_NO_PROBLEMS;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    for (i = 0; i < 8'h3E; i++) rd(8'(i), 32'h0);
    idle();
    // every class and outcome once, plus packets that must not count
    for (i = 0; i < 25; i++) begin
      n = 16'($random(seed));
      rps_dp_model_i.rx(3'(i / 5), 3'(i % 5), n, 1'b1, 1'b0);
      if (i % 5 == 0) fwd += {16'h0, n}; else flt += {16'h0, n};
      rps_dp_model_i.rx(3'(i / 5), 3'(i % 5), ~n, i[0], i[0]);
    end
    `CHK("rx_led", 1'b1, rx_led_o)
    for (i = 0; i < 25; i++) rd(8'(i), 32'h1);
    rd(rps_pkg::A_RX_FWD_B, fwd);
    rd(rps_pkg::A_RX_FLT_B, flt);
    rd(rps_pkg::A_RX_TOTAL, 32'h19);
    idle();
    repeat (12) @(posedge clk_i);
    `CHK("rx_led", 1'b0, rx_led_o)
    // transmit classes, errors beside and apart from sent packets
    for (i = 0; i < 5; i++) repeat (i + 1) rps_dp_model_i.tx(3'(i), 1'b0, 1'b1);
    rps_dp_model_i.tx(3'h0, 1'b1, 1'b1);
    `CHK("tx_led", 1'b1, tx_led_o)
    rps_dp_model_i.tx(3'h1, 1'b1, 1'b0);
    rps_dp_model_i.tx(3'h2, 1'b1, 1'b0);
    for (i = 0; i < 5; i++) rd(8'h20 + 8'(i), 32'(i + 1 + (i == 0)));
    rd(rps_pkg::A_TX_TOTAL, 32'h12);
    idle();
    // drop bit j pulsed j+1 times, several reasons at once
    for (i = 0; i < 7; i++) rps_dp_model_i.drop(7'(7'h7F << i));
    for (i = 0; i < 7; i++) rd(dadr[i], 32'(i + 1));
    // status codes and buffer count
    for (i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rd_i <= 1'b0;
      ring_state_i <= rps_pkg::rps_ring_t'(i % 3);
      span_state_i <= rps_pkg::rps_span_t'(i % 6);
      ring_status_i <= rps_pkg::rps_rstat_t'(i);
      buffers_i <= 16'($random(seed));
      @(posedge clk_i);
      rd(rps_pkg::A_STATUS, {20'h0, 4'(i), 1'b0, 3'(i % 6), 2'b0, 2'(i % 3)});
      rd(rps_pkg::A_BUFFERS, {16'h0, buffers_i});
      idle();
      #1 `CHK("span_pass", i % 6 == 3, span_pass_o)
    end
    // control word, read-only target, unmapped read, indicators
    wr(rps_pkg::A_CONTROL, 32'h1);
    wr(rps_pkg::A_RX_TOTAL, 32'hFFFF_FFFF);
    rd(rps_pkg::A_CONTROL, 32'h1);
    rd(rps_pkg::A_RX_TOTAL, 32'h19);
    rd(8'h50, 32'h0);
    wr(rps_pkg::A_CONTROL, 32'h2);
    `CHK("speed_led", 1'b1, speed_led_o)
    idle();
    repeat (2) @(posedge clk_i);
    #1 `CHK("speed_led", 1'b0, speed_led_o)
    `CHK("processor_ready_led_led", 1'b1, processor_ready_led_o)
    for (i = 0; i < 2; i++) begin
      @(posedge clk_i);
      inserted_i <= ~i[0];
      repeat (2) @(posedge clk_i);
      #1 `CHK("ring_led", ~i[0], ring_inserted_led_o)
    end
    // port restart clears counters, keeps control
    @(posedge clk_i);
    restart_i <= 1'b1;
    @(posedge clk_i);
    restart_i <= 1'b0;
    rd(8'h07, 32'h0);
    rd(rps_pkg::A_RX_TOTAL, 32'h0);
    rd(rps_pkg::A_TX_TOTAL, 32'h0);
    rd(rps_pkg::A_RX_FWD_B, 32'h0);
    rd(rps_pkg::A_RX_SIZE, 32'h0);
    rd(rps_pkg::A_CONTROL, 32'h2);
    wr(rps_pkg::A_CONTROL, 32'h0);
    idle();
    repeat (3) @(posedge clk_i);
    conclude();
  end
endmodule
